// ==== logic/wdtr_pkg.sv ====
package wdtr_pkg;
  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam int unsigned WDTR_CNT_W = 25;
  // Interrupt timeout exponents for select codes 00, 01, 10, 11
  localparam int unsigned WDTR_EXP_SEL0 = 15;
  localparam int unsigned WDTR_EXP_SEL1 = 18;
  localparam int unsigned WDTR_EXP_SEL2 = 21;
  localparam int unsigned WDTR_EXP_SEL3 = 24;
  localparam logic [1:0] WDTR_SEL_RST = 2'h0;
  // Reset window after the interrupt timeout, in system clock cycles
  localparam logic [9:0] WDTR_RST_WINDOW = 10'h200;
  // Length of the system reset pulse, in cycles
  localparam logic [3:0] WDTR_RST_PULSE = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    WDTR_ST_COUNT = 3'h1,
    WDTR_ST_WINDOW = 3'h2,
    WDTR_ST_RESET = 3'h4
  } wdtr_state_e;
endpackage

// ==== logic/wdtr_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two flip-flop synchroniser for a level from outside the clock domain
module wdtr_sync
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;

  // ------------------------------------------------------------
  // Synchroniser stages
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_r <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // wdtr_sync
`default_nettype wire

// ==== logic/wdtr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Free-running counter, periodic restart prevents action
// - Select picks 2^15/2^18/2^21/2^24 cycle timeout
// - Interrupt on timeout only when enabled
// - System reset 512 cycles after timeout
// - One counter drives both timeout stages
// - Full system reset; interrupt optional
module wdtr_top
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic ENABLE_I,
  input wire logic [1:0] TIMEOUT_SELECT_I,
  input wire logic INT_ENABLE_I,
  input wire logic RESTART_I,
  output logic IRQ_O,
  output logic SYS_RESET_O,
  output logic WINDOW_O
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    wdtr_pkg::wdtr_state_e state;
    logic [wdtr_pkg::WDTR_CNT_W-1:0] cnt;
    logic [1:0] sel;
    logic irq;
    logic sys_reset;
    logic window;
    logic [3:0] pulse;
    logic restart_d;
  } wdtr_state_s;

  wdtr_state_s st_r;
  wdtr_state_s st_nxt;
  logic restart_s;
  logic restart_edge;
  logic clear_req;
  logic [3:0] tc_code;
  logic tc_hit;
  logic win_end;

  // Restart strobe comes from the software domain as a level
  // Only the second flip-flop of the synchroniser is read here,
  // so a metastable first stage never reaches the counter logic
  wdtr_sync u_sync
  (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .d_i(RESTART_I),
    .q_o(restart_s)
  );

  // ------------------------------------------------------------
  // Timeout decode
  // ------------------------------------------------------------
  // One terminal-count flag per select code
  // Each flag compares against a constant, so the compare is cheap
  // and no adder sits in the path from the counter to the state
  for (genvar gi = 0; gi < 4; gi++)
  begin : g_tc
    // Exponent of this code's interrupt timeout
    localparam int unsigned EXP = (gi == 0) ? wdtr_pkg::WDTR_EXP_SEL0 :
                                  (gi == 1) ? wdtr_pkg::WDTR_EXP_SEL1 :
                                  (gi == 2) ? wdtr_pkg::WDTR_EXP_SEL2 :
                                  wdtr_pkg::WDTR_EXP_SEL3;
    // Counter-wide one, used to build the terminal count
    localparam logic [wdtr_pkg::WDTR_CNT_W-1:0] ONE = {{(wdtr_pkg::WDTR_CNT_W-1){1'b0}}, 1'b1};
    // Last count before the timeout, 2^EXP - 1
    localparam logic [wdtr_pkg::WDTR_CNT_W-1:0] LAST = (ONE << EXP) - ONE;
    assign tc_code[gi] = (st_r.cnt == LAST);
  end

  // The latched select picks the active flag
  assign tc_hit = tc_code[st_r.sel];

  // ------------------------------------------------------------
  // Event decode
  // ------------------------------------------------------------
  // Rising edge of the synchronised restart level
  // A held restart level restarts only once; software must drop it
  assign restart_edge = restart_s && !st_r.restart_d;
  // A low enable holds the counter as a standing restart
  assign clear_req = !ENABLE_I || restart_edge;
  // Last cycle of the reset window, counted on the same counter
  assign win_end = (st_r.cnt[9:0] == wdtr_pkg::WDTR_RST_WINDOW - 10'h001);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.restart_d = restart_s;
    st_nxt.irq = 1'b0;
    st_nxt.sys_reset = 1'b0;
    case (st_r.state)
      wdtr_pkg::WDTR_ST_COUNT:
      begin
        // Select follows the input only while counting
        st_nxt.sel = TIMEOUT_SELECT_I;
        // A restart that meets the terminal count wins
        if (clear_req)
        begin
          st_nxt.cnt = '0;
        end
        else if (tc_hit)
        begin
          // Same counter restarts from zero for the reset window
          st_nxt.cnt = '0;
          st_nxt.state = wdtr_pkg::WDTR_ST_WINDOW;
          st_nxt.window = 1'b1;
          st_nxt.irq = INT_ENABLE_I;
        end
        else
        begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end
      wdtr_pkg::WDTR_ST_WINDOW:
      begin
        // Window open: a restart still saves the system
        if (clear_req)
        begin
          // Restart drops the window and rearms the interrupt stage
          st_nxt.cnt = '0;
          st_nxt.window = 1'b0;
          st_nxt.state = wdtr_pkg::WDTR_ST_COUNT;
        end
        else if (win_end)
        begin
          st_nxt.cnt = '0;
          st_nxt.window = 1'b0;
          st_nxt.sys_reset = 1'b1;
          st_nxt.pulse = wdtr_pkg::WDTR_RST_PULSE - 1'b1;
          st_nxt.state = wdtr_pkg::WDTR_ST_RESET;
        end
        else
        begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end
      wdtr_pkg::WDTR_ST_RESET:
      begin
        // Hold the system reset for a fixed pulse, then start over
        if (st_r.pulse == 4'h0)
        begin
          st_nxt.state = wdtr_pkg::WDTR_ST_COUNT;
        end
        else
        begin
          st_nxt.sys_reset = 1'b1;
          st_nxt.pulse = st_r.pulse - 1'b1;
        end
      end
      default:
      begin
        st_nxt.state = wdtr_pkg::WDTR_ST_COUNT;
        st_nxt.cnt = '0;
        st_nxt.window = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      st_r.state <= wdtr_pkg::WDTR_ST_COUNT;
      st_r.cnt <= '0;
      st_r.sel <= wdtr_pkg::WDTR_SEL_RST;
      st_r.irq <= 1'b0;
      st_r.sys_reset <= 1'b0;
      st_r.window <= 1'b0;
      st_r.pulse <= 4'h0;
      st_r.restart_d <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Outputs straight from flip-flops, free of decode glitches
  assign IRQ_O = st_r.irq;
  assign SYS_RESET_O = st_r.sys_reset;
  assign WINDOW_O = st_r.window;
endmodule // wdtr_top
`default_nettype wire

// ==== verif/test_watchdog_timeout_reset.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_timeout_reset;
  logic CLK_I, RSTN_I, RESTART_I, INT_ENABLE_I, IRQ_O, SYS_RESET_O, WINDOW_O;
  logic ENABLE_I, win_d, rst_d;
  logic [1:0] TIMEOUT_SELECT_I;
  int unsigned fail_count, cmp_count, t_rs, t_win;
  int unsigned cyc = 0;
  logic [1:0] exp_q[$];
  logic [31:0] rng;
  wdtr_top i_dut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ENABLE_I(ENABLE_I),
    .TIMEOUT_SELECT_I(TIMEOUT_SELECT_I),
    .INT_ENABLE_I(INT_ENABLE_I), .RESTART_I(RESTART_I), .IRQ_O(IRQ_O),
    .SYS_RESET_O(SYS_RESET_O), .WINDOW_O(WINDOW_O));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish(input bit hung);
    if (hung)
      fail_count++;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction
  // Restart pulse of random length
  task automatic pulse();
    rng = xorshift(rng);
    @(posedge CLK_I);
    RESTART_I <= 1'b1;
    t_rs = cyc;
    repeat (2 + rng[1:0]) @(posedge CLK_I);
    RESTART_I <= 1'b0;
  endtask
  initial
  begin
    CLK_I = 1'b0;
    forever #10 CLK_I = ~CLK_I;
  end
  // Cycle count, hang limit and output watcher
  always @(posedge CLK_I)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
      tally_and_finish(1);
    win_d <= WINDOW_O;
    rst_d <= SYS_RESET_O;
    if (WINDOW_O === 1'b1 && win_d === 1'b0)
      t_win = cyc;
    if (IRQ_O === 1'b1 || (SYS_RESET_O === 1'b1 && rst_d === 1'b0))
    begin
      check({IRQ_O, SYS_RESET_O}, exp_q.size() > 0 ? exp_q.pop_front() : 2'h3);
      if (IRQ_O === 1'b1)
        check(cyc - t_rs - (1 << wdtr_pkg::WDTR_EXP_SEL0) <= 6, 1);
      else
        check(cyc - t_win, wdtr_pkg::WDTR_RST_WINDOW);
    end
  end
  initial
  begin
    rng = 32'h0000EF37;
    win_d = 1'b0;
    rst_d = 1'b0;
    ENABLE_I = 1'b1;
    TIMEOUT_SELECT_I = 2'h0;
    RSTN_I = 1'b0;
    RESTART_I = 1'b0;
    INT_ENABLE_I = 1'b1;
    repeat (20) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    // Restart in time, then let it run out
    repeat (1000 + rng[13:0]) @(posedge CLK_I);
    pulse();
    exp_q.push_back(2'h2);
    exp_q.push_back(2'h1);
    wait (SYS_RESET_O === 1'b1);
    $display("test timeout_and_reset done");
    // Silent timeout, restart inside the window
    @(posedge CLK_I);
    INT_ENABLE_I <= 1'b0;
    wait (WINDOW_O === 1'b1);
    repeat (100) @(posedge CLK_I);
    pulse();
    repeat (600) @(posedge CLK_I);
    check(WINDOW_O, 0);
    check(exp_q.size(), 0);
    $display("test window_restart done");
    tally_and_finish(0);
  end
endmodule // test_watchdog_timeout_reset
`default_nettype wire

// ==== verif/wdtr_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdtr_chk
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic INT_ENABLE_I,
  input wire logic RESTART_I,
  input wire logic IRQ_O,
  input wire logic SYS_RESET_O,
  input wire logic WINDOW_O
);
  logic [10:0] win_r;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  // Counts cycles spent in the reset window
  always_ff @(posedge CLK_I or negedge RSTN_I)
    if (!RSTN_I)
      win_r <= 11'h000;
    else
      win_r <= WINDOW_O ? win_r + 11'h001 : 11'h000;
  // Output relations
  chk_irq_enabled: assert property (IRQ_O |-> $past(INT_ENABLE_I))
    else $error("interrupt while disabled");
  chk_irq_pulse: assert property (IRQ_O |=> !IRQ_O)
    else $error("interrupt too long");
  chk_irq_window: assert property (IRQ_O |-> $rose(WINDOW_O))
    else $error("window not opened");
  chk_rst_delay: assert property ($rose(SYS_RESET_O) |-> win_r == 11'h200)
    else $error("reset delay wrong");
  chk_rst_length: assert property ($rose(SYS_RESET_O) |-> SYS_RESET_O[*8] ##1 !SYS_RESET_O)
    else $error("reset length wrong");
  chk_rst_after_win: assert property ($rose(SYS_RESET_O) |-> $fell(WINDOW_O))
    else $error("reset outside window");
  chk_restart_clear: assert property ($rose(RESTART_I) && WINDOW_O |-> ##[1:5] !WINDOW_O)
    else $error("restart kept window");
  cover property (IRQ_O);
  cover property ($rose(SYS_RESET_O));
  cover property ($rose(RESTART_I) && WINDOW_O);
endmodule // wdtr_chk
bind wdtr_top wdtr_chk i_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .INT_ENABLE_I(INT_ENABLE_I),
  .RESTART_I(RESTART_I), .IRQ_O(IRQ_O), .SYS_RESET_O(SYS_RESET_O), .WINDOW_O(WINDOW_O));
`default_nettype wire
